// file: eeprom_link_if.sv
// Purpose: two-wire link between the bus master and the memory slave
// Assumes: both lines are open drain with a pull-up
// Notes:   a line is low while any enabled driver drives low
`timescale 1ns/1ps
`default_nettype none
interface eeprom_link_if;
   logic scl;
   logic sda;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;

   assign scl = host_scl_oe ? host_scl_o : 1'b1;
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// file: eeprom_map.svh
// Purpose: constants shared by both ends of the serial memory read link
// Assumes: included by bare name
// Notes:   definitions only
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

`define DEV_TYPE_CODE  4'ha
`define ADDR_BITS      17
`define BYTE_BITS      4'd8
`define ACK_SLOT       4'd8
`define QUARTER_CYCLES 6
`define SYNC_RESET     4'hc
`define CNT_RESET      17'h00000

`endif

// file: eeprom_pkg.sv
// Purpose: types shared by both ends of the serial memory read link
// Assumes: nothing
// Notes:   numbers live in eeprom_map.svh
package eeprom_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_rx,
      st_ack,
      st_tx,
      st_mack
   } dev_state_t;

   typedef enum logic [2:0] {
      h_idle,
      h_start,
      h_send,
      h_recv,
      h_stop
   } host_state_t;

endpackage

// file: eeprom_read_checker.sv
// Purpose: wire-level checks on the two-wire read link
// Assumes: both ends run on i_mclk; STRAPS equals the slave strap pins
// Notes:   frame position is rebuilt here from the resolved wire levels
`timescale 1ns/1ps
`default_nettype none
module eeprom_read_checker #(
   parameter logic [1:0] STRAPS = 2'h2
)(
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_nrst,
   // link
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic host_sda_oe,
   input  wire logic dev_sda_oe
);
   logic       scl_q;
   logic       sda_q;
   logic       rd;
   logic       nacked;
   logic [3:0] bitn;
   logic [7:0] sh;
   logic [7:0] byten;
   logic       start;
   logic       stop;
   logic       rise;
   logic       ack_rise;
   logic       addr_ok;

   assign start    = scl & scl_q & sda_q & ~sda;
   assign stop     = scl & scl_q & ~sda_q & sda;
   assign rise     = scl & ~scl_q;
   assign ack_rise = rise & (bitn == 4'h8);
   assign addr_ok  = (sh[7:2] == {4'ha, STRAPS});

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // a repeated start restarts the count; byte count saturates on long reads
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         bitn  <= 4'h0;
         byten <= 8'h00;
         sh    <= 8'h00;
         rd    <= 1'b0;
      end else if (start) begin
         bitn  <= 4'h0;
         byten <= 8'h00;
         rd    <= 1'b0;
      end else if (ack_rise) begin
         bitn  <= 4'h0;
         byten <= (byten == 8'hff) ? byten : byten + 8'h01;
         // a refused address starts no read; the stop that follows is the master's
         if (byten == 8'h00)
            rd <= sh[0] & ~sda;
      end else if (rise) begin
         bitn <= bitn + 4'h1;
         sh   <= {sh[6:0], sda};
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst)
         nacked <= 1'b0;
      else if (start)
         nacked <= 1'b0;
      else if (ack_rise && rd && byten != 8'h00 && sda)
         nacked <= 1'b1;
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   property p_change_low;
      $changed(dev_sda_oe) |-> !scl;
   endproperty
   a_change_low: assert property (p_change_low)
      else $error("slave data moved while clock high");
   property p_start_by_host;
      start |-> host_sda_oe;
   endproperty
   a_start_by_host: assert property (p_start_by_host)
      else $error("start edge not made by master");
   property p_addr_ack;
      ack_rise && byten == 8'h00 && addr_ok |-> !sda;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address not acknowledged");
   property p_addr_refuse;
      ack_rise && byten == 8'h00 && !addr_ok |-> sda;
   endproperty
   a_addr_refuse: assert property (p_addr_refuse)
      else $error("foreign address acknowledged");
   property p_mack_release;
      ack_rise && rd && byten != 8'h00 |-> !dev_sda_oe;
   endproperty
   a_mack_release: assert property (p_mack_release)
      else $error("slave drives during master ack");
   property p_host_quiet;
      rise && bitn != 4'h8 && rd && byten != 8'h00 && !nacked |-> !host_sda_oe;
   endproperty
   a_host_quiet: assert property (p_host_quiet)
      else $error("master drives data during read byte");
   property p_nack_quiet;
      nacked |-> !dev_sda_oe;
   endproperty
   a_nack_quiet: assert property (p_nack_quiet)
      else $error("slave drives after no-ack");
   property p_stop_after_nack;
      $rose(nacked) |-> ##[1:80] stop;
   endproperty
   a_stop_after_nack: assert property (p_stop_after_nack)
      else $error("no stop after final no-ack");
endmodule
`default_nettype wire

// file: eeprom_read_dev.sv
// Purpose: memory slave end of the two-wire link, read path
// Assumes: serial clock and data are sampled by i_mclk, many times per bit
// Notes:   writes are acked and dropped; only the address phase is kept
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"
module eeprom_read_dev
   import eeprom_pkg::*;
#(
   parameter int ADDR_W = `ADDR_BITS
)(
   // clock, reset, enable
   input  wire logic              i_mclk,
   input  wire logic              i_nrst,
   input  wire logic              i_ce,
   // link
   eeprom_link_if.dev             link,
   // chip select straps
   input  wire logic              i_cs_strap_high,
   input  wire logic              i_cs_strap_low,
   // memory preload
   input  wire logic              i_load_en,
   input  wire logic [ADDR_W-1:0] i_load_addr,
   input  wire logic [7:0]        i_load_data,
   // status
   output logic                   o_busy,
   output logic [ADDR_W-1:0]      o_word_addr
);
   if (ADDR_W < 9 || ADDR_W > 17) begin : g_bad_addr
      $error("ADDR_W must lie in 9..17");
   end

   localparam int DEPTH = 2 ** ADDR_W;

   logic [7:0]        mem [DEPTH];
   logic [3:0]        s1;
   logic [3:0]        s2;
   logic [3:0]        s3;
   logic [3:0]        filt;
   logic [3:0]        agree;
   logic              scl_q;
   logic              sda_q;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_c;
   logic              stop_c;
   dev_state_t        state;
   logic [3:0]        bitcnt;
   logic [7:0]        sreg;
   logic [7:0]        txsh;
   logic [1:0]        byte_idx;
   logic              is_read;
   logic              page;
   logic [7:0]        addr_hi;
   logic              macked;
   logic              drive;
   logic [ADDR_W-1:0] cnt;
   logic [16:0]       addr_full;
   logic              byte_done;
   logic              addr_match;
   logic              fetch;
   logic              addr_load;

   // pins pass three flops; a change counts once the last two agree
   assign agree = ~(s2 ^ s3);

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1    <= `SYNC_RESET;
         s2    <= `SYNC_RESET;
         s3    <= `SYNC_RESET;
         filt  <= `SYNC_RESET;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (i_ce) begin
         s1    <= {link.scl, link.sda, i_cs_strap_high, i_cs_strap_low};
         s2    <= s1;
         s3    <= s2;
         filt  <= (agree & s3) | (~agree & filt);
         scl_q <= filt[3];
         sda_q <= filt[2];
      end
   end

   assign scl_rise = filt[3] && !scl_q;
   assign scl_fall = !filt[3] && scl_q;
   assign start_c  = filt[3] && scl_q && sda_q && !filt[2];
   assign stop_c   = filt[3] && scl_q && !sda_q && filt[2];

   assign byte_done  = (state == st_rx) && (bitcnt == `BYTE_BITS);
   assign addr_match = (sreg[7:4] == `DEV_TYPE_CODE) &&
                       (sreg[3] == filt[1]) && (sreg[2] == filt[0]);
   assign addr_full  = {page, addr_hi, sreg};
   assign addr_load  = scl_fall && byte_done && !is_read && (byte_idx == 2'd2);
   assign fetch      = scl_fall && (((state == st_ack) && is_read) ||
                                    ((state == st_mack) && macked));

   // preload port; no reset so the array maps to plain storage
   always_ff @(posedge i_mclk) begin
      if (i_ce && i_load_en) begin
         mem[i_load_addr] <= i_load_data;
      end
   end

   // counter is touched by no Start or Stop, only by loads and fetches
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= ADDR_W'(`CNT_RESET);
      end else if (i_ce) begin
         if (addr_load) begin
            cnt <= addr_full[ADDR_W-1:0];
         end else if (fetch) begin
            cnt <= cnt + ADDR_W'(1);
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state    <= st_idle;
         bitcnt   <= 4'h0;
         sreg     <= 8'h00;
         txsh     <= 8'h00;
         byte_idx <= 2'd0;
         is_read  <= 1'b0;
         page     <= 1'b0;
         addr_hi  <= 8'h00;
         macked   <= 1'b0;
         drive    <= 1'b0;
      end else if (i_ce) begin
         if (start_c) begin
            state    <= st_rx;
            bitcnt   <= 4'h0;
            byte_idx <= 2'd0;
            is_read  <= 1'b0;
            drive    <= 1'b0;
         end else if (stop_c) begin
            state <= st_idle;
            drive <= 1'b0;
         end else begin
            case (state)
               st_rx: begin
                  if (scl_rise) begin
                     sreg   <= {sreg[6:0], filt[2]};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && byte_done) begin
                     if (byte_idx != 2'd0 || addr_match) begin
                        state <= st_ack;
                        drive <= 1'b1;
                     end else begin
                        state <= st_idle;
                     end
                     if (byte_idx == 2'd0) begin
                        page    <= sreg[1];
                        is_read <= sreg[0];
                     end
                     if (byte_idx == 2'd1) begin
                        addr_hi <= sreg;
                     end
                     if (byte_idx != 2'd3) begin
                        byte_idx <= byte_idx + 2'd1;
                     end
                  end
               end
               st_ack: begin
                  if (scl_fall) begin
                     bitcnt <= 4'h0;
                     if (is_read) begin
                        txsh  <= mem[cnt];
                        drive <= !mem[cnt][7];
                        state <= st_tx;
                     end else begin
                        drive <= 1'b0;
                        state <= st_rx;
                     end
                  end
               end
               st_tx: begin
                  if (scl_rise) begin
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bitcnt == `BYTE_BITS) begin
                        drive <= 1'b0;
                        state <= st_mack;
                     end else begin
                        txsh  <= {txsh[6:0], 1'b0};
                        drive <= !txsh[6];
                     end
                  end
               end
               st_mack: begin
                  if (scl_rise) begin
                     macked <= !filt[2];
                  end else if (scl_fall) begin
                     bitcnt <= 4'h0;
                     if (macked) begin
                        txsh  <= mem[cnt];
                        drive <= !mem[cnt][7];
                        state <= st_tx;
                     end else begin
                        state <= st_idle;
                     end
                  end
               end
               default: begin
                  drive <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_busy <= 1'b0;
      end else if (i_ce) begin
         o_busy <= (state != st_idle);
      end
   end

   assign o_word_addr     = cnt;
   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = drive;
endmodule
`default_nettype wire

// file: eeprom_read_host.sv
// Purpose: bus master end: current-address, random and sequential reads
// Assumes: this end makes the serial clock by dividing i_mclk
// Notes:   one bit slot is four quarters of QUARTER cycles each
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"
module eeprom_read_host
   import eeprom_pkg::*;
#(
   parameter int QUARTER = `QUARTER_CYCLES
)(
   // clock, reset, enable
   input  wire logic        i_mclk,
   input  wire logic        i_nrst,
   input  wire logic        i_ce,
   // link
   eeprom_link_if.host      link,
   // request
   input  wire logic        i_req,
   input  wire logic        i_random,
   input  wire logic [16:0] i_addr,
   input  wire logic [7:0]  i_count,
   input  wire logic        i_cs_high,
   input  wire logic        i_cs_low,
   // answer
   output logic             o_busy,
   output logic             o_rd_valid,
   output logic [7:0]       o_rd_data,
   output logic             o_done,
   output logic             o_nack
);
   // the slave lets go of sda five cycles after a clock fall; a shorter first
   // quarter of a repeated start would let that release land with scl high
   if (QUARTER < 6 || QUARTER > 255) begin : g_bad_quarter
      $error("QUARTER must lie in 6..255");
   end

   localparam logic [7:0] QLAST = 8'(QUARTER - 1);

   host_state_t state;
   logic [1:0]  ph;
   logic [7:0]  qcnt;
   logic [3:0]  bn;
   logic [7:0]  txb;
   logic [7:0]  rxb;
   logic [1:0]  wsel;
   logic        restarted;
   logic        random;
   logic [16:0] addr;
   logic [1:0]  cs;
   logic [7:0]  remaining;
   logic [2:0]  sync;
   logic        sda_f;
   logic        scl_low;
   logic        sda_low;
   logic        slot_end;
   logic        wr_phase;

   assign slot_end = (qcnt == QLAST) && (ph == 2'd3);
   assign wr_phase = random && !restarted;

   // sda goes through three flops; a change counts once the last two agree
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync  <= 3'h7;
         sda_f <= 1'b1;
      end else if (i_ce) begin
         sync <= {sync[1:0], link.sda};
         if (sync[1] == sync[2]) begin
            sda_f <= sync[2];
         end
      end
   end

   // line levels per slot kind and quarter
   always_comb begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      case (state)
         h_start: begin
            scl_low = (ph == 2'd0) || (ph == 2'd3);
            sda_low = ph[1];
         end
         h_stop: begin
            scl_low = (ph == 2'd0);
            sda_low = !ph[1];
         end
         h_send: begin
            scl_low = !ph[1];
            sda_low = (bn != `ACK_SLOT) && !txb[7];
         end
         h_recv: begin
            scl_low = !ph[1];
            sda_low = (bn == `ACK_SLOT) && (remaining != 8'h01);
         end
         default: begin
            scl_low = 1'b0;
            sda_low = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         link.host_scl_oe <= 1'b0;
         link.host_sda_oe <= 1'b0;
      end else if (i_ce) begin
         link.host_scl_oe <= scl_low;
         link.host_sda_oe <= sda_low;
      end
   end

   assign link.host_scl_o = 1'b0;
   assign link.host_sda_o = 1'b0;

   // clock divider: quarters advance only inside a transfer
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         qcnt <= 8'h00;
         ph   <= 2'd0;
      end else if (i_ce) begin
         if (state == h_idle || qcnt == QLAST) begin
            qcnt <= 8'h00;
         end else begin
            qcnt <= qcnt + 8'h01;
         end
         if (state == h_idle) begin
            ph <= 2'd0;
         end else if (qcnt == QLAST) begin
            ph <= ph + 2'd1;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state      <= h_idle;
         bn         <= 4'h0;
         txb        <= 8'h00;
         rxb        <= 8'h00;
         wsel       <= 2'd0;
         restarted  <= 1'b0;
         random     <= 1'b0;
         addr       <= 17'h00000;
         cs         <= 2'b00;
         remaining  <= 8'h00;
         o_rd_valid <= 1'b0;
         o_rd_data  <= 8'h00;
         o_done     <= 1'b0;
         o_nack     <= 1'b0;
      end else if (i_ce) begin
         o_rd_valid <= 1'b0;
         o_done     <= 1'b0;
         o_nack     <= 1'b0;
         case (state)
            h_idle: begin
               if (i_req) begin
                  random    <= i_random;
                  addr      <= i_addr;
                  cs        <= {i_cs_high, i_cs_low};
                  remaining <= (i_count == 8'h00) ? 8'h01 : i_count;
                  restarted <= 1'b0;
                  state     <= h_start;
               end
            end
            h_start: begin
               if (slot_end) begin
                  txb   <= {`DEV_TYPE_CODE, cs, addr[16], !wr_phase};
                  bn    <= 4'h0;
                  wsel  <= 2'd0;
                  state <= h_send;
               end
            end
            h_send: begin
               if (slot_end) begin
                  if (bn != `ACK_SLOT) begin
                     bn  <= bn + 4'h1;
                     txb <= {txb[6:0], 1'b0};
                  end else begin
                     bn <= 4'h0;
                     if (sda_f) begin
                        o_nack <= 1'b1;
                        state  <= h_stop;
                     end else if (wr_phase) begin
                        case (wsel)
                           2'd0: begin
                              txb  <= addr[15:8];
                              wsel <= 2'd1;
                           end
                           2'd1: begin
                              txb  <= addr[7:0];
                              wsel <= 2'd2;
                           end
                           default: begin
                              restarted <= 1'b1;
                              state     <= h_start;
                           end
                        endcase
                     end else begin
                        state <= h_recv;
                     end
                  end
               end
            end
            h_recv: begin
               if (slot_end) begin
                  if (bn != `ACK_SLOT) begin
                     bn  <= bn + 4'h1;
                     rxb <= {rxb[6:0], sda_f};
                     if (bn == 4'h7) begin
                        o_rd_valid <= 1'b1;
                        o_rd_data  <= {rxb[6:0], sda_f};
                     end
                  end else begin
                     bn <= 4'h0;
                     if (remaining == 8'h01) begin
                        state <= h_stop;
                     end else begin
                        remaining <= remaining - 8'h01;
                     end
                  end
               end
            end
            h_stop: begin
               if (slot_end) begin
                  o_done <= 1'b1;
                  state  <= h_idle;
               end
            end
            default: state <= h_idle;
         endcase
      end
   end

   assign o_busy = (state != h_idle);
endmodule
`default_nettype wire

// file: serial_eeprom_read_path_test.sv
// Purpose: both ends joined on one link, reads checked against a memory model
// Assumes: slave straps are high/low; slave address width cut to 10 bits
// Notes:   the model keeps its own word counter; refused reads leave it alone
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_path_test;
   localparam int AW  = 10;
   localparam int MSZ = 1 << AW;
   logic          i_mclk, i_nrst, ce, req, rnd, cs_h, load_en;
   logic [16:0]   addr;
   logic [7:0]    count, load_data, h_data;
   logic [AW-1:0] load_addr, word_addr;
   logic          h_busy, h_valid, h_done, h_nack, d_busy;
   logic [7:0]    mem [MSZ];
   int            n_fail, comparisons, cycles, cnt;

   eeprom_link_if eeprom_link_if_i ();
   eeprom_read_host #(.QUARTER(6)) eeprom_read_host_i (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce), .link(eeprom_link_if_i.host),
      .i_req(req), .i_random(rnd), .i_addr(addr), .i_count(count), .i_cs_high(cs_h),
      .i_cs_low(1'b0), .o_busy(h_busy), .o_rd_valid(h_valid), .o_rd_data(h_data),
      .o_done(h_done), .o_nack(h_nack));
   eeprom_read_dev #(.ADDR_W(AW)) eeprom_read_dev_i (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce), .link(eeprom_link_if_i.dev),
      .i_cs_strap_high(1'b1), .i_cs_strap_low(1'b0), .i_load_en(load_en),
      .i_load_addr(load_addr), .i_load_data(load_data), .o_busy(d_busy),
      .o_word_addr(word_addr));
   eeprom_read_checker #(.STRAPS(2'h2)) eeprom_read_checker_i (
      .i_mclk(i_mclk), .i_nrst(i_nrst), .scl(eeprom_link_if_i.scl),
      .sda(eeprom_link_if_i.sda), .host_sda_oe(eeprom_link_if_i.host_sda_oe),
      .dev_sda_oe(eeprom_link_if_i.dev_sda_oe));

   always #20 i_mclk = ~i_mclk;

   task automatic cmp_data(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_val(input string what, input logic [16:0] exp, input logic [16:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one whole transfer; the bound covers the longest read issued here
   task automatic rd_op(input string name, input bit r, input int a, input int n, input bit ok);
      int   got;
      int   want;
      logic nk;
      want = (n == 0) ? 1 : n;
      got = 0;
      nk = 1'b0;
      @(negedge i_mclk);
      req = 1'b1;
      rnd = r;
      addr = a[16:0];
      count = n[7:0];
      cs_h = ok;
      @(negedge i_mclk);
      req = 1'b0;
      if (r && ok)
         cnt = a % MSZ;
      for (int k = 0; k < 30000 && h_busy !== 1'b0; k++) begin
         if (h_valid === 1'b1) begin
            cmp_data("read byte", mem[cnt], h_data);
            cnt = (cnt + 1) % MSZ;
            got++;
         end
         nk = nk | (h_nack === 1'b1);
         @(negedge i_mclk);
      end
      cmp_val("host idle", 17'h0, {16'h0000, h_busy});
      cmp_val("done pulse", 17'h1, {16'h0000, h_done});
      cmp_val("byte count", ok ? want : 0, 17'(got));
      cmp_val("address refused", {16'h0000, !ok}, {16'h0000, nk});
      @(negedge i_mclk);
      cmp_val("word counter", 17'(cnt), {7'h00, word_addr});
      cmp_val("slave busy", 17'h0, {16'h0000, d_busy});
      cmp_val("idle lines", 17'h3, {15'h0000, eeprom_link_if_i.scl, eeprom_link_if_i.sda});
      $display("test %s done", name);
   endtask

   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 90000) begin
         n_fail++;
         $display("timeout reached");
         summarize();
      end
   end

   initial begin
      i_mclk = 1'b0;
      i_nrst = 1'b0;
      ce = 1'b1;
      req = 1'b0;
      rnd = 1'b0;
      cs_h = 1'b1;
      addr = 17'h00000;
      count = 8'h00;
      load_en = 1'b0;
      load_addr = '0;
      load_data = 8'h00;
      repeat (8) @(negedge i_mclk);
      i_nrst = 1'b1;
      void'($urandom(33));
      for (int i = 0; i < MSZ; i++) begin
         @(negedge i_mclk);
         load_en = 1'b1;
         load_addr = i[AW-1:0];
         load_data = 8'($urandom);
         mem[i] = load_data;
      end
      @(negedge i_mclk);
      load_en = 1'b0;
      rd_op("random_one", 1'b1, 'h155, 1, 1'b1);
      rd_op("current_seq", 1'b0, 0, 3, 1'b1);
      rd_op("wrap", 1'b1, 'h1fffe, 4, 1'b1);
      rd_op("current_after", 1'b0, 0, 0, 1'b1);
      rd_op("wrong_select", 1'b1, 'h20, 2, 1'b0);
      rd_op("after_refuse", 1'b0, 0, 2, 1'b1);
      for (int t = 0; t < 12; t++) begin
         rd_op("random_mix", 1'($urandom_range(1, 0)), int'($urandom_range(131071, 0)),
               int'($urandom_range(6, 0)), $urandom_range(3, 0) != 0);
      end
      summarize();
   end
endmodule
`default_nettype wire
